/* include/pwr_state_pkg.sv */
package pwr_state_pkg;
	// ------------------------------------------------------------
	// Command encodings {cs_n, activate_low, ras_n, cas_n, we_n}
	// ------------------------------------------------------------
	localparam logic [4:0] CMD_DES = 5'h10;
	localparam logic [4:0] CMD_NOP = 5'h0F;
	localparam logic [4:0] CMD_MRS = 5'h08;
	localparam logic [4:0] CMD_REF = 5'h09;
	localparam logic [4:0] CMD_PRE = 5'h0A;
	localparam logic [4:0] CMD_ACT = 5'h00;
	localparam logic [4:0] CMD_WR = 5'h0C;
	localparam logic [4:0] CMD_RD = 5'h0D;

	// ------------------------------------------------------------
	// Mode register and latency figures
	// ------------------------------------------------------------
	localparam logic [1:0] MR_ONE_SEL = 2'h1;
	localparam int DLL_BIT_POS = 0;
	localparam logic DLL_OFF_VALUE = 1'b0;
	localparam logic DLL_RESET_VALUE = 1'b1;
	localparam logic [4:0] READ_LATENCY = 5'h0A;
	localparam logic [4:0] WRITE_LATENCY = 5'h09;
	localparam logic [4:0] ADDITIVE_LATENCY = 5'h00;
	localparam int NUM_BANKS = 8;
	localparam logic [3:0] BURST_CYCLES = 4'h4;

	// ------------------------------------------------------------
	// Timing, in link clock cycles; the divider half period is in system clock cycles
	// ------------------------------------------------------------
	localparam logic [3:0] CLOCK_ENABLE_PULSE_CYC = 4'h3;
	localparam logic [3:0] MODE_SET_COMMAND_CYC = 4'h8;
	localparam logic [4:0] MODE_UPDATE_CYC = 5'h18;
	localparam logic [7:0] SELF_REFRESH_EXIT_CYC = 8'h10;
	localparam logic [7:0] SELF_REFRESH_EXIT_RELOCK_CYC = 8'h40;
	localparam logic [3:0] PRECHARGE_CYC = 4'h4;
	localparam logic [7:0] LINK_DIV_HALF = 8'h04; // 50 MHz / 8 gives 160 ns

	// ------------------------------------------------------------
	// Device power state
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		PS_IDLE = 5'b00001,
		PS_ACTIVE = 5'b00010,
		PS_PRE_PD = 5'b00100,
		PS_ACT_PD = 5'b01000,
		PS_SELF_REF = 5'b10000
	} power_state_e;

	// Host sequencer states
	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_ISSUE = 5'b00010,
		HS_HOLD = 5'b00100,
		HS_WAIT = 5'b01000,
		HS_EXIT = 5'b10000
	} host_state_e;

	// Host orders
	localparam logic [2:0] ORD_MRS = 3'h0;
	localparam logic [2:0] ORD_ACT = 3'h1;
	localparam logic [2:0] ORD_RD = 3'h2;
	localparam logic [2:0] ORD_PRE = 3'h3;
	localparam logic [2:0] ORD_PD_ENTER = 3'h4;
	localparam logic [2:0] ORD_SR_ENTER = 3'h5;
	localparam logic [2:0] ORD_LP_EXIT = 3'h6;
	localparam logic [2:0] ORD_WR = 3'h7;

	// Host register map
	localparam logic [1:0] REG_ORDER = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_MODE_DATA = 2'h2;
endpackage : pwr_state_pkg

/* include/dram_link_if.sv */
`timescale 1ns/1ps
interface dram_link_if;
	logic ck;
	logic cke;
	logic cs_n;
	logic activate_low;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] bank;
	logic [13:0] addr;
	logic reset_n;
	logic strobe_out;
	logic strobe_oe_n;
	logic [7:0] dq_out;

	modport ctrl (
		output ck, cke, cs_n, activate_low, ras_n, cas_n, we_n, bank, addr, reset_n,
		input strobe_out, strobe_oe_n, dq_out
	);
	modport dram (
		input ck, cke, cs_n, activate_low, ras_n, cas_n, we_n, bank, addr, reset_n,
		output strobe_out, strobe_oe_n, dq_out
	);
endinterface : dram_link_if

/* core/dram_power_end.sv */
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module dram_power_end
	import pwr_state_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	dram_link_if.dram link,
	output logic [4:0] power_state,
	output logic dll_enabled,
	output logic termination_available,
	output logic refresh_active,
	output logic illegal_seen
);
	// ------------------------------------------------------------
	// Link input synchronisers
	// ------------------------------------------------------------
	// The link clock is sampled like any pin; edges are found after two flops
	logic [9:0] in_meta_r;
	logic [9:0] in_sync_r;
	logic ck_prev_r;
	logic [4:0] cmd;
	logic cke_now;
	logic ck_rise;
	logic dev_rst_n;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			in_meta_r <= 10'h000;
			in_sync_r <= 10'h000;
			ck_prev_r <= 1'b0;
		end else begin
			in_meta_r <= {link.reset_n, link.bank[0], link.addr[DLL_BIT_POS], link.ck, link.cke,
				link.cs_n, link.activate_low, link.ras_n, link.cas_n, link.we_n};
			in_sync_r <= in_meta_r;
			ck_prev_r <= in_sync_r[6];
		end
	end

	assign ck_rise = in_sync_r[6] && !ck_prev_r;
	assign cke_now = in_sync_r[5];
	assign cmd = in_sync_r[4:0];
	assign dev_rst_n = in_sync_r[9];

	// ------------------------------------------------------------
	// Enable history and registered command
	// ------------------------------------------------------------
	logic cke_prev_r;
	logic cmd_valid;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cke_prev_r <= 1'b1; // Idle enable level, so no false edge after reset
		end else if (ck_rise) begin
			cke_prev_r <= cke_now;
		end
	end

	// Chip select high never registers a command; no-operation is not a command either
	assign cmd_valid = !cmd[4] && (cmd != CMD_NOP);

	// ------------------------------------------------------------
	// Bank, burst and timing trackers
	// ------------------------------------------------------------
	logic [NUM_BANKS-1:0] open_r;
	logic [3:0] burst_r;
	logic [3:0] pre_r;
	logic [7:0] exit_r;
	logic [4:0] mode_r;
	logic all_idle;
	logic [2:0] bank_sel;
	logic awake_cmd;
	power_state_e state_r;

	assign bank_sel = {in_sync_r[8], in_sync_r[8], in_sync_r[8]} & 3'h1;
	// Commands count only when awake and enable high on both edges
	assign awake_cmd = ck_rise && cke_prev_r && cke_now && cmd_valid &&
		(state_r == PS_IDLE || state_r == PS_ACTIVE);
	// Burst, precharge, exit and mode timings must be met before self refresh can be entered
	assign all_idle = all_idle_prev(open_r, burst_r) && cke_prev_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			open_r <= '0;
		end else if (!dev_rst_n) begin
			open_r <= '0;
		end else if (awake_cmd && cmd == CMD_ACT) begin
			open_r[bank_sel] <= 1'b1;
		end else if (awake_cmd && cmd == CMD_PRE) begin
			open_r <= '0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			burst_r <= 4'h0;
			pre_r <= 4'h0;
			mode_r <= 5'h00;
		end else if (ck_rise) begin
			// Operations in progress continue regardless of select
			if (awake_cmd && (cmd == CMD_RD || cmd == CMD_WR)) begin
				burst_r <= BURST_CYCLES;
			end else if (burst_r != 4'h0) begin
				burst_r <= burst_r - 4'h1;
			end
			if (awake_cmd && cmd == CMD_PRE) begin
				pre_r <= PRECHARGE_CYC;
			end else if (pre_r != 4'h0) begin
				pre_r <= pre_r - 4'h1;
			end
			if (awake_cmd && cmd == CMD_MRS) begin
				mode_r <= MODE_UPDATE_CYC;
			end else if (mode_r != 5'h00) begin
				mode_r <= mode_r - 5'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	power_state_e state_nxt;
	logic illegal_nxt;

	always_comb begin
		state_nxt = state_r;
		illegal_nxt = 1'b0;
		unique case (state_r)
			PS_IDLE, PS_ACTIVE: begin
				if (cke_prev_r && !cke_now) begin
					if (cmd == CMD_REF && state_r == PS_IDLE && all_idle) begin
						state_nxt = PS_SELF_REF;
					end else if (cmd[4]) begin
						// Closed banks after a precharge still give precharge power-down
						state_nxt = (open_r == '0) ? PS_PRE_PD : PS_ACT_PD;
					end else begin
						illegal_nxt = 1'b1;
					end
				end else if (cke_prev_r) begin
					state_nxt = (open_r == '0 && burst_r == 4'h0) ? PS_IDLE : PS_ACTIVE;
				end
			end
			PS_PRE_PD, PS_ACT_PD: begin
				// Pins ignored while enable stays low
				if (!cke_prev_r && cke_now) begin
					state_nxt = (open_r == '0) ? PS_IDLE : PS_ACTIVE;
					illegal_nxt = !cmd[4];
				end
			end
			PS_SELF_REF: begin
				if (!cke_prev_r && cke_now) begin
					state_nxt = PS_IDLE;
					illegal_nxt = !cmd[4] && (cmd != CMD_NOP);
				end
			end
		endcase
	end

	function automatic logic all_idle_prev(input logic [NUM_BANKS-1:0] o, input logic [3:0] b);
		all_idle_prev = (o == '0) && (b == 4'h0) && (pre_r == 4'h0) && (exit_r == 8'h00)
			&& (mode_r == 5'h00);
	endfunction : all_idle_prev

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= PS_IDLE;
			illegal_seen <= 1'b0;
		end else if (!dev_rst_n) begin
			state_r <= PS_IDLE;
		end else if (ck_rise) begin
			state_r <= state_nxt;
			if (illegal_nxt) begin
				illegal_seen <= 1'b1;
			end
		end
	end

	// Exit recovery count restarts on each self-refresh exit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			exit_r <= 8'h00;
		end else if (ck_rise) begin
			if (state_r == PS_SELF_REF && state_nxt == PS_IDLE) begin
				exit_r <= SELF_REFRESH_EXIT_RELOCK_CYC;
			end else if (exit_r != 8'h00) begin
				exit_r <= exit_r - 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Dll control and read strobe timing
	// ------------------------------------------------------------
	logic [4:0] rd_cnt_r;
	logic dll_bit;

	assign dll_bit = in_sync_r[7];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dll_enabled <= 1'b1;
		end else if (awake_cmd && cmd == CMD_MRS && bank_sel[0] == MR_ONE_SEL[0]) begin
			dll_enabled <= (dll_bit != DLL_OFF_VALUE);
		end
	end

	// Strobe reference is one cycle earlier with the DLL off
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_cnt_r <= 5'h00;
		end else if (ck_rise) begin
			if (awake_cmd && cmd == CMD_RD) begin
				rd_cnt_r <= dll_enabled ? (ADDITIVE_LATENCY + READ_LATENCY) :
					(ADDITIVE_LATENCY + READ_LATENCY - 5'h01);
			end else if (rd_cnt_r != 5'h00) begin
				rd_cnt_r <= rd_cnt_r - 5'h01;
			end
		end
	end

	// Data follows the strobe directly; only the clock reference moves
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			link.strobe_out <= 1'b0;
			link.strobe_oe_n <= 1'b1;
			link.dq_out <= 8'h00;
		end else begin
			link.strobe_oe_n <= !(rd_cnt_r == 5'h01);
			link.strobe_out <= (rd_cnt_r == 5'h01);
			link.dq_out <= (rd_cnt_r == 5'h01) ? 8'hA5 : 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			power_state <= 5'h01;
			termination_available <= 1'b1;
			refresh_active <= 1'b0;
		end else begin
			power_state <= state_r;
			termination_available <= (state_r != PS_SELF_REF);
			refresh_active <= (state_r == PS_SELF_REF);
		end
	end
endmodule : dram_power_end

/* core/dram_ctrl_end.sv */
`timescale 1ns/1ps
module dram_ctrl_end
	import pwr_state_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	dram_link_if.ctrl link,
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata
);
	// ------------------------------------------------------------
	// Link clock divider; command, address and enable changes follow its falling edge
	// ------------------------------------------------------------
	logic [7:0] div_r;
	logic ck_fall;

	// Fixed slow rate in every mode; no periodic refresh is issued, so long idles are the user's risk
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 8'h00;
			link.ck <= 1'b0;
		end else if (div_r == LINK_DIV_HALF - 8'h01) begin
			div_r <= 8'h00;
			link.ck <= !link.ck;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	assign ck_fall = (div_r == LINK_DIV_HALF - 8'h01) && link.ck;

	// ------------------------------------------------------------
	// Order register and sequencer
	// ------------------------------------------------------------
	host_state_e st_r;
	logic [2:0] ord_r;
	logic ord_pend_r;
	logic [13:0] mode_data_r;
	logic [7:0] wait_r;
	logic [7:0] relock_r;
	logic [4:0] mode_gap_r;
	logic [3:0] pulse_r;
	logic in_self_ref_r;
	logic init_done_r;
	logic busy;

	assign busy = (st_r != HS_IDLE) || ord_pend_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ord_r <= ORD_MRS;
			ord_pend_r <= 1'b0;
			mode_data_r <= 14'h0000;
		end else begin
			if (reg_wr && reg_addr == REG_MODE_DATA) begin
				mode_data_r <= reg_wdata[13:0];
			end
			// Orders written while busy are dropped
			if (reg_wr && reg_addr == REG_ORDER && !busy) begin
				ord_r <= reg_wdata[2:0];
				ord_pend_r <= 1'b1;
			end else if (st_r == HS_ISSUE) begin
				ord_pend_r <= 1'b0;
			end
		end
	end

	// Enable level held for the pulse time; low only after mode delays
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= HS_IDLE;
			link.cke <= 1'b1;
			link.cs_n <= 1'b1;
			{link.activate_low, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
			link.bank <= 2'h0;
			link.addr <= 14'h0000;
			wait_r <= 8'h00;
			relock_r <= 8'h00;
			mode_gap_r <= 5'h00;
			pulse_r <= 4'h0;
			in_self_ref_r <= 1'b0;
			init_done_r <= 1'b0;
		end else if (ck_fall) begin
			link.cs_n <= 1'b1; // default deselect
			if (wait_r != 8'h00) wait_r <= wait_r - 8'h01;
			if (relock_r != 8'h00) relock_r <= relock_r - 8'h01;
			if (mode_gap_r != 5'h00) mode_gap_r <= mode_gap_r - 5'h01;
			if (pulse_r != 4'h0) pulse_r <= pulse_r - 4'h1;
			unique case (st_r)
				HS_IDLE: if (ord_pend_r && pulse_r == 4'h0 && wait_r == 8'h00) st_r <= HS_ISSUE;
				HS_ISSUE: begin
					st_r <= HS_HOLD;
					// Any other order ends initialisation; self refresh ignores mode writes
					if (ord_r != ORD_MRS) begin
						init_done_r <= 1'b1;
					end
					unique case (ord_r)
						ORD_MRS: if (!init_done_r) begin
							{link.cs_n, link.activate_low, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
							link.bank <= MR_ONE_SEL;
							link.addr <= mode_data_r;
							mode_gap_r <= MODE_UPDATE_CYC;
						end
						ORD_ACT: {link.cs_n, link.activate_low, link.ras_n, link.cas_n, link.we_n} <= CMD_ACT;
						ORD_RD: if (relock_r == 8'h00) begin
							{link.cs_n, link.activate_low, link.ras_n, link.cas_n, link.we_n} <= CMD_RD;
						end
						ORD_WR: {link.cs_n, link.activate_low, link.ras_n, link.cas_n, link.we_n} <= CMD_WR;
						ORD_PRE: {link.cs_n, link.activate_low, link.ras_n, link.cas_n, link.we_n} <= CMD_PRE;
						ORD_PD_ENTER: if (mode_gap_r == 5'h00 && link.cke) begin
							link.cke <= 1'b0;
							pulse_r <= CLOCK_ENABLE_PULSE_CYC;
						end
						ORD_SR_ENTER: if (mode_gap_r == 5'h00 && link.cke) begin
							link.cke <= 1'b0;
							{link.cs_n, link.activate_low, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
							pulse_r <= CLOCK_ENABLE_PULSE_CYC;
							in_self_ref_r <= 1'b1;
						end
						ORD_LP_EXIT: if (!link.cke) begin
							link.cke <= 1'b1; // exit with deselect
							pulse_r <= CLOCK_ENABLE_PULSE_CYC;
							if (in_self_ref_r) begin
								wait_r <= SELF_REFRESH_EXIT_CYC;
								relock_r <= SELF_REFRESH_EXIT_RELOCK_CYC;
							end
							in_self_ref_r <= 1'b0;
						end
						default: ;
					endcase
				end
				HS_HOLD: st_r <= HS_IDLE; // one order at a time
				HS_WAIT, HS_EXIT: st_r <= HS_IDLE;
				default: st_r <= HS_IDLE;
			endcase
		end
	end

	// Device reset kept high during normal work
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			link.reset_n <= 1'b0;
		end else begin
			link.reset_n <= 1'b1;
		end
	end

	// Status read: one cycle later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_ORDER: reg_rdata <= {13'h0000, ord_r};
				REG_STATUS: reg_rdata <= {12'h000, (relock_r != 8'h00), in_self_ref_r, link.cke, busy};
				REG_MODE_DATA: reg_rdata <= {2'h0, mode_data_r};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : dram_ctrl_end

/* sim/dram_power_properties.sv */
`timescale 1ns/1ps
// ----------
// Link protocol checker
// ----------
module dram_power_properties
	import pwr_state_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic activate_low,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic strobe_out,
	input wire logic strobe_oe_n
);
	logic [4:0] cmd;
	logic [4:0] cmd_q_r;
	logic cke_q_r;
	logic sr_r;
	logic new_cmd;
	logic [9:0] hold_r;
	logic [9:0] mode_r;
	logic [9:0] exit_r;
	logic [9:0] rd_r;

	assign cmd = {cs_n, activate_low, ras_n, cas_n, we_n};
	assign new_cmd = cmd != cmd_q_r;

	// Previous samples; self refresh seen as enable falling with chip select low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cke_q_r <= 1'b1;
			cmd_q_r <= CMD_DES;
			sr_r <= 1'b0;
		end else begin
			cke_q_r <= cke;
			cmd_q_r <= cmd;
			if (!cke && cke_q_r && !cs_n) begin
				sr_r <= 1'b1;
			end else if (cke && !cke_q_r) begin
				sr_r <= 1'b0;
			end
		end
	end

	// Timers; saturate so a long idle never wraps into a false pass
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 10'h3FF;
			mode_r <= 10'h3FF;
			rd_r <= 10'h3FF;
			exit_r <= 10'h000;
		end else begin
			hold_r <= (cke != cke_q_r) ? 10'h000 : hold_r + {9'h000, hold_r != 10'h3FF};
			mode_r <= (new_cmd && cmd == CMD_MRS) ? 10'h000 : mode_r + {9'h000, mode_r != 10'h3FF};
			rd_r <= (new_cmd && cmd == CMD_RD) ? 10'h000 : rd_r + {9'h000, rd_r != 10'h3FF};
			if (cke && !cke_q_r && sr_r) begin
				exit_r <= 10'h1F4;
			end else if (exit_r != 10'h000) begin
				exit_r <= exit_r - 10'h001;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_enable_hold: assert property ((cke != cke_q_r) |-> hold_r >= 10'h00F)
		else $error("enable toggled too soon");
	a_mode_settle: assert property ($fell(cke) |-> mode_r >= 10'h0B4)
		else $error("enable low inside mode update time");
	a_entry_command: assert property ($fell(cke) |-> cs_n || cmd == CMD_REF)
		else $error("bad command on enable fall");
	a_exit_deselect: assert property ($rose(cke) |-> cs_n)
		else $error("exit without deselect");
	a_recovery_deselect: assert property (exit_r > 10'h17C |-> cs_n)
		else $error("command inside exit recovery");
	a_relock_read: assert property ((new_cmd && cmd == CMD_RD) |-> exit_r == 10'h000)
		else $error("read before relock");
	a_nop_unused: assert property (cmd != CMD_NOP)
		else $error("no-operation command used");
	a_strobe_latency: assert property ($rose(strobe_out) |-> rd_r inside {[10'h040:10'h060]})
		else $error("read strobe at wrong time");
	a_strobe_driven: assert property (strobe_out |-> !strobe_oe_n)
		else $error("read strobe high while not driven");
	a_reset_held: assert property ($past(rst_n) && $past(rst_n, 2) |-> reset_n)
		else $error("device reset driven low");
endmodule : dram_power_properties

/* sim/dram_power_state_dll_off_control_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module dram_power_state_dll_off_control_tb
	import pwr_state_pkg::*;
;
	typedef struct {logic [2:0] ord; logic [15:0] mode; logic [15:0] pause; logic [4:0] ps;} row_s;
	logic clk_sys, rst_n, reg_wr, reg_rd, strobe_q;
	logic [1:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, st;
	logic [4:0] power_state, lcmd, lcmd_q;
	logic dll_enabled, termination_available, refresh_active, illegal_seen;
	int fails, checks_done, cyc, rd_t, lat, lat_on, strobes, n;
	row_s rows [10];

	// ----------
	// Ends, link and checker
	// ----------
	dram_link_if link_if ();
	dram_ctrl_end dram_ctrl_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if.ctrl),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	dram_power_end dram_power_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if.dram),
		.power_state(power_state), .dll_enabled(dll_enabled),
		.termination_available(termination_available), .refresh_active(refresh_active),
		.illegal_seen(illegal_seen));
	dram_power_properties dram_power_properties_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.cke(link_if.cke), .cs_n(link_if.cs_n), .activate_low(link_if.activate_low),
		.ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
		.reset_n(link_if.reset_n), .strobe_out(link_if.strobe_out),
		.strobe_oe_n(link_if.strobe_oe_n));

	// Clock and watchdog; a hang counts as a mismatch
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#1000000;
		fails++;
		stop_test();
	end

	// Read-to-strobe distance, measured on the link itself
	assign lcmd = {link_if.cs_n, link_if.activate_low, link_if.ras_n, link_if.cas_n, link_if.we_n};
	always @(posedge clk_sys) begin
		cyc++;
		lcmd_q <= lcmd;
		strobe_q <= link_if.strobe_out;
		if (lcmd == CMD_RD && lcmd_q != CMD_RD) rd_t = cyc;
		if (link_if.strobe_out === 1'b1 && strobe_q === 1'b0) begin
			lat = cyc - rd_t;
			strobes++;
		end
	end

	// ----------
	// Register bus tasks
	// ----------
	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd_reg

	// Order then poll busy; the poll count bounds a stuck sequencer
	task automatic do_order(input logic [2:0] o, input logic [15:0] m);
		logic [15:0] s;
		int k;
		s = 16'h0001;
		k = 0;
		wr_reg(REG_MODE_DATA, m);
		wr_reg(REG_ORDER, {13'h0000, o});
		while (s[0] !== 1'b0 && k < 3000) begin
			rd_reg(REG_STATUS, s);
			k++;
		end
		`CHK("busy", 1'b0, s[0])
	endtask : do_order

	task automatic settle(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask : settle

	task automatic stop_test();
		if (fails == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// ----------
	// Main sequence
	// ----------
	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{fails, checks_done, cyc, rd_t, lat, strobes} = '0;
		rows = '{'{ORD_ACT, 16'h0000, 16'h0028, PS_ACTIVE}, '{ORD_RD, 16'h0000, 16'h00C8, PS_ACTIVE},
			'{ORD_PD_ENTER, 16'h0000, 16'h0028, PS_ACT_PD}, '{ORD_LP_EXIT, 16'h0000, 16'h0028, PS_ACTIVE},
			'{ORD_WR, 16'h0000, 16'h0064, PS_ACTIVE}, '{ORD_PRE, 16'h0000, 16'h0028, PS_IDLE},
			'{ORD_PD_ENTER, 16'h0000, 16'h0028, PS_PRE_PD}, '{ORD_LP_EXIT, 16'h0000, 16'h0028, PS_IDLE},
			'{ORD_SR_ENTER, 16'h0000, 16'h0028, PS_SELF_REF}, '{ORD_LP_EXIT, 16'h0000, 16'h0258, PS_IDLE}};
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			do_order(rows[i].ord, rows[i].mode);
			settle(rows[i].pause);
			`CHK("power_state", rows[i].ps, power_state)
			`CHK("refresh", rows[i].ps == PS_SELF_REF, refresh_active)
			`CHK("termination", rows[i].ps != PS_SELF_REF, termination_available)
		end
		lat_on = lat;
		// Status in self refresh, then a read while the relock runs
		do_order(ORD_SR_ENTER, 16'h0000);
		rd_reg(REG_STATUS, st);
		`CHK("status", 2'h2, st[2:1])
		do_order(ORD_LP_EXIT, 16'h0000);
		n = strobes;
		do_order(ORD_RD, 16'h0000);
		settle(150);
		`CHK("strobes", n, strobes)
		settle(600);
		rd_reg(2'h3, st);
		`CHK("unmapped", 16'h0000, st)
		`CHK("illegal", 1'b0, illegal_seen)
		// Second reset, then DLL off at initialisation
		@(posedge clk_sys);
		rst_n <= 1'b0;
		settle(8);
		`CHK("reset state", PS_IDLE, power_state)
		`CHK("reset dll", 1'b1, dll_enabled)
		`CHK("reset strobe", 1'b1, link_if.strobe_oe_n)
		@(posedge clk_sys);
		rst_n <= 1'b1;
		do_order(ORD_MRS, {MR_ONE_SEL, 14'h0000});
		do_order(ORD_PD_ENTER, 16'h0000);
		settle(16);
		`CHK("dll off", 1'b0, dll_enabled)
		`CHK("early pd", PS_IDLE, power_state)
		settle(260);
		do_order(ORD_ACT, 16'h0000);
		do_order(ORD_RD, 16'h0000);
		settle(200);
		`CHK("strobe lead", 2 * int'(LINK_DIV_HALF), lat_on - lat)
		// A mode write after initialisation must not reach the device
		do_order(ORD_MRS, {MR_ONE_SEL, 14'h0001});
		`CHK("late dll", 1'b0, dll_enabled)
		`CHK("illegal after reset", 1'b0, illegal_seen)
		stop_test();
	end
endmodule : dram_power_state_dll_off_control_tb
